//--- core/udic_pkg.sv
// package with register map, field positions and timing for the usb irq/control block
package udic_pkg;
  localparam logic [7:0] UDIC_ADDR_DEVCTRL = 8'hc1;
  localparam logic [7:0] UDIC_ADDR_PWRDN = 8'hc2;
  localparam logic [7:0] UDIC_ADDR_EPREQ = 8'hc4;
  localparam logic [7:0] UDIC_ADDR_SUMMARY = 8'hd6;
  localparam logic [7:0] UDIC_ADDR_SELECT = 8'hd2;
  localparam logic [7:0] UDIC_SEL_DEVICE = 8'h80;
  localparam logic [7:0] UDIC_SEL_RESET = 8'h80;
  localparam int UDIC_NUM_EP = 5;
  // device control bit positions
  localparam int UDIC_DC_SPEED = 7;
  localparam int UDIC_DC_ATTACH = 6;
  localparam int UDIC_DC_SWR = 5;
  localparam int UDIC_DC_BUS_IDLE_SLEEP = 4;
  localparam int UDIC_DC_INIT = 3;
  localparam int UDIC_DC_WAKE = 2;
  localparam int UDIC_DC_UCLK = 1;
  localparam int UDIC_DC_PCLK = 0;
  localparam int UDIC_SUM_REQ = 7;
  localparam int UDIC_PD_REQ_EN = 7;
  localparam int UDIC_EPBC_FWD = 4;
  localparam int UDIC_IRQ_ENABLE_REG0_GLOBAL = 7;
  localparam int UDIC_IRQ_ENABLE_REG1_USB_EP = 1;
  // timing
  localparam int UDIC_CLK_HZ = 25000000;
  localparam int UDIC_IDLE_US = 3000;
  localparam int UDIC_IDLE_CYC = UDIC_CLK_HZ / 1000000 * UDIC_IDLE_US + 1;
  localparam int UDIC_SWR_CYC = 16;
  typedef enum logic [1:0] {UDIC_RST_IDLE = 2'b00, UDIC_RST_RUN = 2'b01,
                            UDIC_RST_DONE = 2'b11} udic_rst_e;
endpackage : udic_pkg

//--- core/udic_sfr_if.sv
// interface bundling the sfr access strobes inside the main block; no helper module uses it
`timescale 1ns/100ps
interface udic_sfr_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  modport master (output wr, output rd, output addr, output wdata);
  modport slave (input wr, input rd, input addr, input wdata);
endinterface : udic_sfr_if

//--- core/udic_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module udic_sync #(
  parameter int W = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else if (i_ce)
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule : udic_sync

//--- core/udic_top.sv
// usb device summary flags, device control/status register and interrupt request
`timescale 1ns/100ps
module udic_top
  import udic_pkg::*;
#(
  parameter int IDLE_CYC = UDIC_IDLE_CYC,
  parameter int SWR_CYC = UDIC_SWR_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_attach_pin,
  input wire logic i_bus_idle,
  input wire logic i_req_value_evt,
  input wire logic [UDIC_NUM_EP-1:0] i_ep_evt,
  input wire logic [7:0] i_power_down_reg,
  input wire logic [UDIC_NUM_EP-1:0] i_ep_forward_en,
  input wire logic [7:0] i_irq_enable_reg0,
  input wire logic [7:0] i_irq_enable_reg1,
  input wire logic i_init_done,
  output logic o_full_speed,
  output logic o_clock_multiplier,
  output logic o_core_clk_en,
  output logic o_func_reset,
  output logic o_remote_wake,
  output logic o_irq
);
  // refuse counts that the idle and reset counters cannot hold
  if (IDLE_CYC < 2 || SWR_CYC < 1 || SWR_CYC > 65536)
  begin : g_bad_param
    $error("udic_top: bad timing parameters");
  end

  udic_sfr_if sfr ();
  assign sfr.wr = i_sfr_wr;
  assign sfr.rd = i_sfr_rd;
  assign sfr.addr = i_sfr_addr;
  assign sfr.wdata = i_sfr_wdata;

  logic [1:0] pins_sync;
  logic attach_sense;
  logic bus_idle_s;
  udic_sync #(.W(2)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_d({i_attach_pin, i_bus_idle}),
    .o_q(pins_sync)
  );
  assign attach_sense = pins_sync[1];
  assign bus_idle_s = pins_sync[0];

  logic [7:0] block_selector;
  logic dev_sel;
  logic wr_sel;
  logic wr_dc;
  logic wr_sum;
  logic rd_epreq;
  logic [2:0] ep_idx;
  // device block window only at selector 80h
  assign dev_sel = (block_selector == UDIC_SEL_DEVICE);
  assign ep_idx = block_selector[2:0];
  assign wr_sel = i_ce && sfr.wr && (sfr.addr == UDIC_ADDR_SELECT);
  assign wr_dc = i_ce && sfr.wr && dev_sel && (sfr.addr == UDIC_ADDR_DEVCTRL);
  assign wr_sum = i_ce && sfr.wr && (sfr.addr == UDIC_ADDR_SUMMARY);
  assign rd_epreq = i_ce && sfr.rd && !block_selector[7] && (sfr.addr == UDIC_ADDR_EPREQ);

  // selector register
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      block_selector <= UDIC_SEL_RESET;
    else if (wr_sel)
      block_selector <= sfr.wdata;
  end

  // endpoint pending flags; a new event wins over the read clear
  logic [UDIC_NUM_EP-1:0] endpoint_irq_pending;
  genvar g;
  generate
    for (g = 0; g < UDIC_NUM_EP; g++)
    begin : g_ep
      always_ff @(posedge i_sys_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          endpoint_irq_pending[g] <= 1'b0;
        else if (i_ce)
        begin
          if (i_ep_evt[g])
            endpoint_irq_pending[g] <= 1'b1;
          else if (rd_epreq && ep_idx == 3'(g))
            endpoint_irq_pending[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // request value flag: set wins, zero write clears, one write ignored
  logic request_value_flag;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      request_value_flag <= 1'b0;
    else if (i_ce)
    begin
      if (i_req_value_evt)
        request_value_flag <= 1'b1;
      else if (wr_sum && !sfr.wdata[UDIC_SUM_REQ])
        request_value_flag <= 1'b0;
    end
  end

  // soft reset sequencer: counter stands in for the function's reset time
  udic_rst_e rst_state;
  logic [15:0] rst_cnt;
  logic module_soft_reset;
  logic init_pending;
  assign module_soft_reset = (rst_state != UDIC_RST_IDLE);
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_state <= UDIC_RST_IDLE;
      rst_cnt <= '0;
    end
    else if (i_ce)
    begin
      case (rst_state)
        UDIC_RST_IDLE:
        begin
          if (wr_dc && sfr.wdata[UDIC_DC_SWR])
          begin
            rst_state <= UDIC_RST_RUN;
            rst_cnt <= '0;
          end
        end
        UDIC_RST_RUN:
        begin
          rst_cnt <= rst_cnt + 16'h0001;
          if (rst_cnt == 16'(SWR_CYC - 1))
            rst_state <= UDIC_RST_DONE;
        end
        UDIC_RST_DONE: rst_state <= UDIC_RST_IDLE;
        default: rst_state <= UDIC_RST_IDLE;
      endcase
    end
  end

  // init pending: raised at reset end, dropped by the init sequence
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      init_pending <= 1'b0;
    else if (i_ce)
    begin
      if (rst_state == UDIC_RST_DONE)
        init_pending <= 1'b1;
      else if (i_init_done)
        init_pending <= 1'b0;
    end
  end

  // speed and clock selects; speed only moves with a soft reset write
  logic speed;
  logic uclk;
  logic pclk;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      speed <= 1'b0;
      uclk <= 1'b0;
      pclk <= 1'b0;
    end
    else if (wr_dc)
    begin
      if (sfr.wdata[UDIC_DC_SWR])
        speed <= sfr.wdata[UDIC_DC_SPEED];
      uclk <= sfr.wdata[UDIC_DC_UCLK];
      pclk <= sfr.wdata[UDIC_DC_PCLK];
    end
  end
  assign o_full_speed = speed;
  assign o_clock_multiplier = pclk;
  assign o_core_clk_en = uclk;
  assign o_func_reset = module_soft_reset;

  // idle counter and suspend status
  logic [31:0] idle_cnt;
  logic bus_idle_sleep;
  logic remote_wake_request;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      idle_cnt <= '0;
    else if (i_ce)
    begin
      if (!bus_idle_s)
        idle_cnt <= '0;
      else if (idle_cnt != 32'(IDLE_CYC))
        idle_cnt <= idle_cnt + 32'h1;
    end
  end

  logic wake_write;
  assign wake_write = wr_dc && sfr.wdata[UDIC_DC_WAKE] && bus_idle_sleep;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      bus_idle_sleep <= 1'b0;
    else if (i_ce)
    begin
      if (!bus_idle_s || wake_write)
        bus_idle_sleep <= 1'b0;
      else if (idle_cnt == 32'(IDLE_CYC - 1))
        bus_idle_sleep <= 1'b1;
    end
  end

  // wake request set by a wake write while suspended; that write ends suspend, so it clears the next cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      remote_wake_request <= 1'b0;
    else if (i_ce)
    begin
      if (!bus_idle_sleep && !wake_write)
        remote_wake_request <= 1'b0;
      else if (wake_write)
        remote_wake_request <= 1'b1;
    end
  end
  assign o_remote_wake = remote_wake_request;

  // interrupt: OR of each flag gated by its enables
  logic ep_irq;
  logic req_irq;
  assign ep_irq = |(endpoint_irq_pending & i_ep_forward_en)
    && i_irq_enable_reg0[UDIC_IRQ_ENABLE_REG0_GLOBAL] && i_irq_enable_reg1[UDIC_IRQ_ENABLE_REG1_USB_EP];
  assign req_irq = request_value_flag && i_power_down_reg[UDIC_PD_REQ_EN];
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= ep_irq || req_irq;
  end

  // read mux; reserved bits read zero
  always_comb
  begin
    o_sfr_rdata = 8'h00;
    if (sfr.addr == UDIC_ADDR_SUMMARY)
    begin
      o_sfr_rdata[UDIC_SUM_REQ] = request_value_flag;
      o_sfr_rdata[UDIC_NUM_EP-1:0] = endpoint_irq_pending;
    end
    else if (sfr.addr == UDIC_ADDR_SELECT)
      o_sfr_rdata = block_selector;
    else if (sfr.addr == UDIC_ADDR_DEVCTRL && dev_sel)
    begin
      o_sfr_rdata[UDIC_DC_SPEED] = speed;
      o_sfr_rdata[UDIC_DC_ATTACH] = attach_sense;
      o_sfr_rdata[UDIC_DC_SWR] = module_soft_reset;
      o_sfr_rdata[UDIC_DC_BUS_IDLE_SLEEP] = bus_idle_sleep;
      o_sfr_rdata[UDIC_DC_INIT] = init_pending;
      o_sfr_rdata[UDIC_DC_WAKE] = remote_wake_request;
      o_sfr_rdata[UDIC_DC_UCLK] = uclk;
      o_sfr_rdata[UDIC_DC_PCLK] = pclk;
    end
  end

  // checks
  chk_req_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_ce && i_req_value_evt |=> request_value_flag) else $error("request flag not set");
  chk_req_one_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    request_value_flag && wr_sum && sfr.wdata[UDIC_SUM_REQ] |=> request_value_flag)
    else $error("request flag lost on write one");
  chk_speed_guard: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !(wr_dc && sfr.wdata[UDIC_DC_SWR]) |=> $stable(speed))
    else $error("speed changed without soft reset");
  chk_swr_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(module_soft_reset) |-> ##[1:40] !module_soft_reset)
    else $error("soft reset never ends");
  chk_init_after: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(module_soft_reset) |-> init_pending) else $error("init pending not raised");
  chk_wake_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !bus_idle_sleep && !$past(wake_write) |-> !remote_wake_request)
    else $error("wake request without suspend");
  chk_bus_idle_sleep_drop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_ce && !bus_idle_s |=> !bus_idle_sleep) else $error("suspend held on activity");
  chk_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_ce && !ep_irq && !req_irq |=> !o_irq) else $error("irq without enabled flag");
  chk_pend_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    rd_epreq && ep_idx == 3'd0 && !i_ep_evt[0] |=> !endpoint_irq_pending[0])
    else $error("pending not cleared on read");
  cov_soft_reset: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(module_soft_reset));
  cov_suspend: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(bus_idle_sleep));
  cov_irq: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_irq));
endmodule : udic_top

//--- dv/udic_host_model.sv
// behavioural usb host side: request pulses, endpoint events, bus idle level
`timescale 1ns/100ps
module udic_host_model
  import udic_pkg::*;
(
  input wire logic i_sys_clk,
  output logic o_req_value_evt,
  output logic [UDIC_NUM_EP-1:0] o_ep_evt,
  output logic o_bus_idle
);
  initial
  begin
    o_req_value_evt = 1'b0;
    o_ep_evt = '0;
    o_bus_idle = 1'b0;
  end
  // one-cycle set-config/set-interface request
  task send_req();
    @(posedge i_sys_clk);
    #1 o_req_value_evt = 1'b1;
    @(posedge i_sys_clk);
    #1 o_req_value_evt = 1'b0;
  endtask : send_req
  // one endpoint event pulse
  task send_ep(input int n);
    @(posedge i_sys_clk);
    #1 o_ep_evt[n] = 1'b1;
    @(posedge i_sys_clk);
    #1 o_ep_evt = '0;
  endtask : send_ep
  // idle level holds until changed, like a quiet cable
  task set_idle(input logic b);
    @(posedge i_sys_clk);
    #1 o_bus_idle = b;
  endtask : set_idle
endmodule : udic_host_model

//--- dv/tb_usb_device_irq_and_control.sv
// self-checking bench for the usb irq and device control block
`timescale 1ns/100ps
module tb_usb_device_irq_and_control
  import udic_pkg::*;
;
  typedef struct {int ep; logic [4:0] fwd; logic [7:0] ie0; logic [7:0] ie1; logic irq;} udic_row_s;
  logic sys_clk, rst_b, sfr_wr, sfr_rd, attach, init_done, req_evt, idle, ce;
  logic fs, pll, uclk, fres, wake, irq;
  logic [7:0] sfr_addr, sfr_wdata, rdata, pd, ie0, ie1;
  logic [4:0] ep_evt, fwd;
  int error_cnt, check_count;
  udic_row_s rows[8];

  udic_host_model host (.i_sys_clk(sys_clk), .o_req_value_evt(req_evt), .o_ep_evt(ep_evt),
    .o_bus_idle(idle));
  // short idle and soft reset counts keep the run brief
  udic_top #(.IDLE_CYC(20), .SWR_CYC(4)) DUT (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
    .i_ce(ce), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_addr(sfr_addr),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata), .i_attach_pin(attach), .i_bus_idle(idle),
    .i_req_value_evt(req_evt), .i_ep_evt(ep_evt), .i_power_down_reg(pd),
    .i_ep_forward_en(fwd), .i_irq_enable_reg0(ie0), .i_irq_enable_reg1(ie1),
    .i_init_done(init_done), .o_full_speed(fs), .o_clock_multiplier(pll),
    .o_core_clk_en(uclk), .o_func_reset(fres), .o_remote_wake(wake), .o_irq(irq));

  // 25 mhz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (e !== g)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task chk1(input string n, input logic e, input logic g);
    check_count++;
    if (e !== g)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task results();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // one-cycle write strobe; reserved bits always written as zero
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
  endtask : wr

  // read data is combinational, so sample a little after the address settles
  task reg_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    #2 chk8(n, e, rdata);
  endtask : reg_chk

  task bit_chk(input string n, input int b, input logic e);
    @(posedge sys_clk);
    #1 sfr_addr = UDIC_ADDR_DEVCTRL;
    #2 chk1(n, e, rdata[b]);
  endtask : bit_chk

  // bounded wait on a control bit; running out ends the run
  task wait_bit(input int b, input logic v);
    int n;
    n = 0;
    sfr_addr = UDIC_ADDR_DEVCTRL;
    #2;
    while (rdata[b] !== v && n < 100)
    begin
      @(posedge sys_clk);
      #3 n++;
    end
    if (n >= 100)
    begin
      chk1("wait", v, rdata[b]);
      results();
    end
  endtask : wait_bit

  // select the endpoint block, then read its request register
  task rd_clear(input int ep);
    wr(UDIC_ADDR_SELECT, 8'(ep));
    @(posedge sys_clk);
    #1 sfr_addr = UDIC_ADDR_EPREQ;
    sfr_rd = 1'b1;
    @(posedge sys_clk);
    #1 sfr_rd = 1'b0;
  endtask : rd_clear

  initial
  begin
    rows = '{'{0, 5'h1f, 8'h80, 8'h02, 1'b1}, '{1, 5'h1f, 8'h80, 8'h02, 1'b1},
      '{2, 5'h1f, 8'h80, 8'h02, 1'b1}, '{3, 5'h1f, 8'h80, 8'h02, 1'b1},
      '{4, 5'h1f, 8'h80, 8'h02, 1'b1}, '{2, 5'h1b, 8'h80, 8'h02, 1'b0},
      '{3, 5'h1f, 8'h00, 8'h02, 1'b0}, '{4, 5'h1f, 8'h80, 8'h00, 1'b0}};
    {rst_b, sfr_wr, sfr_rd, attach, init_done} = '0;
    ce = 1'b1;
    {sfr_addr, sfr_wdata, pd, ie0, ie1, fwd} = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    reg_chk("dcr", UDIC_ADDR_DEVCTRL, 8'h00);
    chk1("speed", 1'b0, fs);
    chk1("pll", 1'b0, pll);
    reg_chk("summary", UDIC_ADDR_SUMMARY, 8'h00);
    // endpoint rows: flag, gated interrupt, read-clear
    foreach (rows[k])
    begin
      fwd = rows[k].fwd;
      ie0 = rows[k].ie0;
      ie1 = rows[k].ie1;
      host.send_ep(rows[k].ep);
      repeat (2) @(posedge sys_clk);
      reg_chk("summary", UDIC_ADDR_SUMMARY, 8'(8'h01 << rows[k].ep));
      chk1("irq", rows[k].irq, irq);
      rd_clear(rows[k].ep);
      repeat (2) @(posedge sys_clk);
      reg_chk("summary", UDIC_ADDR_SUMMARY, 8'h00);
      chk1("irq", 1'b0, irq);
    end
    wr(UDIC_ADDR_SELECT, UDIC_SEL_DEVICE);
    // attach pin passes through a two-stage synchroniser
    attach = 1'b1;
    repeat (3) @(posedge sys_clk);
    bit_chk("attach", UDIC_DC_ATTACH, 1'b1);
    #1 attach = 1'b0;
    repeat (3) @(posedge sys_clk);
    bit_chk("attach", UDIC_DC_ATTACH, 1'b0);
    // clock enable low: a request pulse must not be taken
    ce = 1'b0;
    host.send_req();
    reg_chk("ce_freeze", UDIC_ADDR_SUMMARY, 8'h00);
    ce = 1'b1;
    // request flag: enable gating, write-one ignored, write-zero clears
    ie1 = 8'hff;
    host.send_req();
    repeat (2) @(posedge sys_clk);
    reg_chk("summary", UDIC_ADDR_SUMMARY, 8'h80);
    chk1("irq", 1'b0, irq);
    #1 pd = 8'h80;
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq", 1'b1, irq);
    wr(UDIC_ADDR_SUMMARY, 8'h80);
    reg_chk("summary", UDIC_ADDR_SUMMARY, 8'h80);
    wr(UDIC_ADDR_SUMMARY, 8'h00);
    reg_chk("summary", UDIC_ADDR_SUMMARY, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq", 1'b0, irq);
    // device block reachable only with selector at 80h
    wr(UDIC_ADDR_SELECT, 8'h00);
    wr(UDIC_ADDR_DEVCTRL, 8'h02);
    chk1("uclk", 1'b0, uclk);
    wr(UDIC_ADDR_SELECT, UDIC_SEL_DEVICE);
    wr(UDIC_ADDR_DEVCTRL, 8'h02);
    chk1("uclk", 1'b1, uclk);
    // speed only moves together with soft reset
    wr(UDIC_ADDR_DEVCTRL, 8'h82);
    chk1("speed", 1'b0, fs);
    wr(UDIC_ADDR_DEVCTRL, 8'ha2);
    chk1("speed", 1'b1, fs);
    chk1("freset", 1'b1, fres);
    wr(UDIC_ADDR_DEVCTRL, 8'h82);
    bit_chk("swr", UDIC_DC_SWR, 1'b1);
    wait_bit(UDIC_DC_SWR, 1'b0);
    chk1("freset", 1'b0, fres);
    bit_chk("init", UDIC_DC_INIT, 1'b1);
    #1 init_done = 1'b1;
    @(posedge sys_clk);
    #1 init_done = 1'b0;
    // suspend only after the idle count, left by wake request or activity
    host.set_idle(1'b1);
    repeat (10) @(posedge sys_clk);
    bit_chk("bus_idle_sleep", UDIC_DC_BUS_IDLE_SLEEP, 1'b0);
    wait_bit(UDIC_DC_BUS_IDLE_SLEEP, 1'b1);
    wr(UDIC_ADDR_DEVCTRL, 8'h06);
    wait_bit(UDIC_DC_BUS_IDLE_SLEEP, 1'b0);
    host.set_idle(1'b0);
    repeat (2) @(posedge sys_clk);
    #1 chk1("wake", 1'b0, wake);
    wr(UDIC_ADDR_DEVCTRL, 8'h06);
    chk1("wake", 1'b0, wake);
    host.set_idle(1'b1);
    wait_bit(UDIC_DC_BUS_IDLE_SLEEP, 1'b1);
    host.set_idle(1'b0);
    wait_bit(UDIC_DC_BUS_IDLE_SLEEP, 1'b0);
    results();
  end
endmodule : tb_usb_device_irq_and_control
